// *** hw/psi_pkg.sv ***
// Package with register map, field positions and reset values of the status block
package psi_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_INT_STATUS  = 10'h00e;
  localparam logic [9:0]  IDX_CORR_FAIL   = 10'h326;
  localparam logic [9:0]  IDX_ERR_LEVEL   = 10'h328;
  localparam logic [9:0]  IDX_INT_ENABLE  = 10'h040;
  localparam logic [9:0]  IDX_MAX_UNCORR  = 10'h041;

  // ----------------------------------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RX         = 0;
  localparam int BIT_TX         = 1;
  localparam int BIT_HOST_ERR   = 2;
  localparam int BIT_FIFO_NE    = 3;
  localparam int BIT_FIFO_OVR   = 4;
  localparam int BIT_CYC_START  = 5;
  localparam int BIT_TIMER0     = 6;
  localparam int BIT_TIMER1     = 7;
  localparam int BIT_OFFS_MISS  = 8;
  localparam int BIT_GUARDIAN   = 9;
  localparam int BIT_SLOT_CNT   = 10;
  localparam int BIT_RATE_MISS  = 11;
  localparam int BIT_LVL_CHANGE = 12;
  localparam int BIT_SYNC_OVF   = 13;
  localparam int BIT_CORR_LIMIT = 14;
  localparam int BIT_FATAL      = 15;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int NUM_BUF         = 59;
  localparam int NUM_SLOT_CNT    = 8;
  localparam logic [15:0] INT_STATUS_RST = 16'h0000;
  localparam logic [15:0] INT_ENABLE_RST = 16'h0000;
  localparam logic [3:0]  CORR_FAIL_RST  = 4'h0;
  localparam logic [3:0]  MAX_UNCORR_RST = 4'hf;

  // Error handling level encoding
  typedef enum logic [1:0] {
    LVL_GREEN  = 2'b00,
    LVL_YELLOW = 2'b01,
    LVL_RED    = 2'b10
  } psi_level_t;

  // Bus handshake states
  typedef enum logic {PSI_IDLE, PSI_ACK} psi_bus_t;

endpackage

// *** hw/psi_status_regs.sv ***
// Protocol status counters, error level and interrupt status register with Avalon-MM slave
//
// How it works
// - Entering normal active clears the correction-failure counter.
// - Odd cycle end with offset or rate correction missing increments the counter.
// - Odd cycle end with no correction missing clears the counter.
// - Counter saturates at the programmed maximum, never wraps.
// - Counter readable in bits 3..0, host writes ignored.
// - Error level read-only: 00 green, 01 yellow, 10 red.
// - Host writes one to clear a status bit; zeros leave bits; events set again.
// - Internal set beats a simultaneous host clear.
// - FIFO, host error, transmit and receive flags ignore clears while cause persists.
// - Status register is zero after reset and on leaving configuration.
// - Each flag has an enable; request stays high while an enabled flag is set.
// - Receive flag set by any enabled receive buffer flag or FIFO reception.
// - Read-only transmit flag follows any enabled empty transmit buffer.
// - FIFO flag set while data held; cleared once empty and buffer 0 unlocked.
// - Overrun sets FIFO overrun flag; cycle start sets cycle start flag.
// - Timer flag set when computed cycle and macrotick offset both match.
// - With zero config and counters both timer flags set right after reset.
// - Every cycle end, missing offset measurements set the offset flag.
// - Odd cycle end, missing rate pairs set the rate flag.
// - Too many sync frames or correction limit set their flags.
// - Fatal condition sets the fatal flag and forces diagnosis stop at once.
// - Level change, guardian, slot counter and host error events set their flags.
//
// Our own choice: the Avalon-MM interface to the registers.
module psi_status_regs
  import psi_pkg::*;
(
  input  wire logic                     mclk,               // 25 MHz clock
  input  wire logic                     rst,                // Async reset, active high
  input  wire logic [11:0]              avs_address,        // Byte address
  input  wire logic                     avs_read,           // Read request
  input  wire logic                     avs_write,          // Write request
  input  wire logic [3:0]               avs_byteenable,     // Byte lanes
  input  wire logic [31:0]              avs_writedata,      // Write data
  output logic      [31:0]              avs_readdata,       // Read data
  output logic                          avs_waitrequest,    // Stall
  input  wire logic                     config_exit,        // Leaving configuration (pulse)
  input  wire logic                     normal_active_enter, // Entering normal active (pulse)
  input  wire logic                     cycle_start,        // Cycle start (pulse)
  input  wire logic                     cycle_end,          // Cycle end (pulse)
  input  wire logic                     cycle_odd,          // Current cycle is odd
  input  wire logic                     offset_meas_low,    // Too few offset measurements
  input  wire logic                     rate_pairs_low,     // Too few rate measurement pairs
  input  wire logic [NUM_BUF-1:0]       buffer_int_flag,    // Per buffer interrupt flag
  input  wire logic [NUM_BUF-1:0]       buffer_int_enable,  // Per buffer interrupt enable
  input  wire logic [NUM_BUF-1:0]       buffer_is_tx,       // Buffer is a transmit buffer
  input  wire logic                     fifo_rx_done,       // FIFO received a frame (pulse)
  input  wire logic                     fifo_not_empty,     // Receive FIFO holds data
  input  wire logic                     mb0_locked,         // Buffer 0 locked by host
  input  wire logic                     fifo_overrun,       // FIFO overrun (pulse)
  input  wire logic                     host_if_error_any,  // Any error bit set
  input  wire logic [5:0]               timer0_cycle,       // Timer 0 computed cycle
  input  wire logic [13:0]              timer0_offset,      // Timer 0 macrotick offset
  input  wire logic [5:0]               timer1_cycle,       // Timer 1 computed cycle
  input  wire logic [13:0]              timer1_offset,      // Timer 1 macrotick offset
  input  wire logic [5:0]               cycle_count_value,  // Current cycle counter
  input  wire logic [13:0]              macrotick_value,    // Current macrotick
  input  wire logic                     sync_overflow,      // Too many sync frames (pulse)
  input  wire logic                     corr_limit,         // Correction limit hit (pulse)
  input  wire logic [1:0]               guardian_error,     // Schedule error per channel
  input  wire logic [NUM_SLOT_CNT-1:0]  slot_counter_inc,   // Slot counter incremented
  input  wire logic [NUM_SLOT_CNT-1:0]  slot_counter_int_mask, // Slot counter enables
  input  wire logic [1:0]               engine_level,       // Level from protocol engine
  input  wire logic                     fatal_detect,       // Illegal condition (pulse)
  output logic                          int_request,        // Interrupt request
  output logic                          diag_stop,          // Diagnosis stop forced
  output logic [1:0]                    error_level_field,  // Current error level
  output logic [3:0]                    correction_fail_count // Correction-failure counter
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  psi_bus_t    bus_reg;
  psi_bus_t    bus_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] isr_reg;
  logic [15:0] isr_next;
  logic [15:0] ier_reg;
  logic [15:0] ier_next;
  logic [3:0]  max_uncorr_reg;
  logic [3:0]  max_uncorr_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [1:0]  lvl_reg;
  logic [1:0]  lvl_next;
  logic        fatal_seen_reg;
  logic        irq_reg;
  logic        wait_reg;

  wire         bus_req      = avs_read | avs_write;
  wire         bus_done     = (bus_reg == PSI_ACK);
  wire         wr_take      = avs_write & bus_done;
  wire         hit_isr      = reg_hit(avs_address, IDX_INT_STATUS);
  wire         hit_cnt      = reg_hit(avs_address, IDX_CORR_FAIL);
  wire         hit_lvl      = reg_hit(avs_address, IDX_ERR_LEVEL);
  wire         hit_ier      = reg_hit(avs_address, IDX_INT_ENABLE);
  wire         hit_max      = reg_hit(avs_address, IDX_MAX_UNCORR);
  wire [15:0]  wmask        = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0]  wdata16      = avs_writedata[15:0] & wmask;
  wire [15:0]  host_clr     = (wr_take && hit_isr) ? wdata16 : 16'h0000;

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign bus_next = (bus_req && !bus_done) ? PSI_ACK : PSI_IDLE;

  assign rdata_next = hit_isr ? {16'h0000, isr_reg} :
                      hit_cnt ? {28'h0000000, cnt_reg} :
                      hit_lvl ? {30'h0000000, lvl_reg} :
                      hit_ier ? {16'h0000, ier_reg} :
                      hit_max ? {28'h0000000, max_uncorr_reg} :
                      32'h00000000;

  assign ier_next = (wr_take && hit_ier) ? ((ier_reg & ~wmask) | wdata16) : ier_reg;
  assign max_uncorr_next = (wr_take && hit_max && avs_byteenable[0]) ?
                           avs_writedata[3:0] : max_uncorr_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bus_reg   <= PSI_IDLE;
      rdata_reg <= 32'h00000000;
      wait_reg  <= 1'b1;
    end
    else
    begin
      bus_reg   <= bus_next;
      rdata_reg <= (bus_req && !bus_done) ? rdata_next : rdata_reg;
      wait_reg  <= (bus_next != PSI_ACK);
    end
  end

  // Stall comes from its own flop so the pin carries no decode
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ier_reg        <= INT_ENABLE_RST;
      max_uncorr_reg <= MAX_UNCORR_RST;
    end
    else
    begin
      ier_reg        <= ier_next;
      max_uncorr_reg <= max_uncorr_next;
    end
  end

  // ----------------------------------------------------------------
  // Correction-failure counter
  // ----------------------------------------------------------------
  wire odd_end    = cycle_end & cycle_odd;
  wire corr_miss  = offset_meas_low | rate_pairs_low;

  assign cnt_next = normal_active_enter ? CORR_FAIL_RST :
                    (odd_end && !corr_miss) ? CORR_FAIL_RST :
                    (odd_end && cnt_reg < max_uncorr_reg) ? cnt_reg + 4'h1 :
                    cnt_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_reg <= CORR_FAIL_RST;
    else
      cnt_reg <= cnt_next;
  end

  // ----------------------------------------------------------------
  // Error handling level
  // ----------------------------------------------------------------
  wire fatal_any = fatal_detect | fatal_seen_reg;
  assign lvl_next = fatal_any ? LVL_RED : engine_level;
  wire lvl_changed = (lvl_next != lvl_reg);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lvl_reg        <= LVL_GREEN;
      fatal_seen_reg <= 1'b0;
    end
    else
    begin
      lvl_reg        <= lvl_next;
      fatal_seen_reg <= fatal_detect | (fatal_seen_reg & ~config_exit);
    end
  end

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  wire [NUM_BUF-1:0] buf_pending = buffer_int_flag & buffer_int_enable;
  wire rx_cond = |(buf_pending & ~buffer_is_tx);
  wire tx_cond = |(buf_pending & buffer_is_tx);
  wire tmr0_hit = (timer0_cycle == cycle_count_value) &&
                  (timer0_offset == macrotick_value);
  wire tmr1_hit = (timer1_cycle == cycle_count_value) &&
                  (timer1_offset == macrotick_value);

  logic [15:0] hw_set;
  logic [15:0] hw_hold;
  logic [15:0] hw_drop;

  always_comb
  begin
    hw_set                 = 16'h0000;
    hw_set[BIT_RX]         = rx_cond | fifo_rx_done;
    hw_set[BIT_TX]         = tx_cond;
    hw_set[BIT_HOST_ERR]   = host_if_error_any;
    hw_set[BIT_FIFO_NE]    = fifo_not_empty;
    hw_set[BIT_FIFO_OVR]   = fifo_overrun;
    hw_set[BIT_CYC_START]  = cycle_start;
    hw_set[BIT_TIMER0]     = tmr0_hit;
    hw_set[BIT_TIMER1]     = tmr1_hit;
    hw_set[BIT_OFFS_MISS]  = cycle_end & offset_meas_low;
    hw_set[BIT_GUARDIAN]   = |guardian_error;
    hw_set[BIT_SLOT_CNT]   = |(slot_counter_inc & slot_counter_int_mask);
    hw_set[BIT_RATE_MISS]  = odd_end & rate_pairs_low;
    hw_set[BIT_LVL_CHANGE] = lvl_changed;
    hw_set[BIT_SYNC_OVF]   = sync_overflow;
    hw_set[BIT_CORR_LIMIT] = corr_limit;
    hw_set[BIT_FATAL]      = fatal_detect;

    // Clears refused while the cause is still present
    hw_hold                = 16'h0000;
    hw_hold[BIT_RX]        = rx_cond;
    hw_hold[BIT_TX]        = 1'b1;
    hw_hold[BIT_HOST_ERR]  = host_if_error_any;
    hw_hold[BIT_FIFO_NE]   = fifo_not_empty | mb0_locked;

    // Flags that drop by themselves once their cause is gone
    hw_drop                = 16'h0000;
    hw_drop[BIT_TX]        = ~tx_cond;
    hw_drop[BIT_FIFO_NE]   = ~fifo_not_empty & ~mb0_locked;
  end

  // ----------------------------------------------------------------
  // Interrupt status register
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_flag
      wire keep = isr_reg[gi] & ~(host_clr[gi] & ~hw_hold[gi]) & ~hw_drop[gi];
      assign isr_next[gi] = config_exit ? 1'b0 : (hw_set[gi] | keep);
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      isr_reg <= INT_STATUS_RST;
      irq_reg <= 1'b0;
    end
    else
    begin
      isr_reg <= isr_next;
      irq_reg <= |(isr_next & ier_next);
    end
  end

  assign int_request           = irq_reg;
  assign diag_stop             = fatal_seen_reg;
  assign error_level_field     = lvl_reg;
  assign correction_fail_count = cnt_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_odd_miss;
    odd_end && corr_miss && !normal_active_enter;
  endsequence

  property p_cnt_clear_active;
    normal_active_enter |=> correction_fail_count == 4'h0;
  endproperty
  a_cnt_clear_active: assert property (p_cnt_clear_active)
    else $error("counter not cleared on normal active");

  property p_cnt_inc;
    s_odd_miss and (cnt_reg < max_uncorr_reg) |=> cnt_reg == $past(cnt_reg) + 4'h1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("counter did not increment");

  property p_cnt_zero;
    odd_end && !corr_miss |=> cnt_reg == 4'h0;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero)
    else $error("counter not cleared at odd end");

  property p_cnt_sat;
    s_odd_miss and (cnt_reg == max_uncorr_reg) |=> $stable(cnt_reg);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat)
    else $error("counter moved past maximum");

  property p_cnt_ro;
    !odd_end && !normal_active_enter |=> $stable(cnt_reg);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro)
    else $error("counter changed without cause");

  property p_lvl_code;
    error_level_field != 2'b11;
  endproperty
  a_lvl_code: assert property (p_lvl_code)
    else $error("unused level code");

  property p_w1c;
    wr_take && hit_isr && !config_exit |=>
      (isr_reg & ~$past(host_clr)) ==
      ((($past(isr_reg) & ~$past(hw_drop)) | $past(hw_set)) & ~$past(host_clr));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("zero write disturbed status");

  property p_set_wins;
    !config_exit && hw_set[BIT_CYC_START] ##0 host_clr[BIT_CYC_START] |=> isr_reg[BIT_CYC_START];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("host clear beat a set");

  property p_hold;
    !config_exit && isr_reg[BIT_FIFO_NE] && mb0_locked |=> isr_reg[BIT_FIFO_NE];
  endproperty
  a_hold: assert property (p_hold)
    else $error("FIFO flag cleared while buffer 0 locked");

  property p_cfg_clear;
    config_exit |=> isr_reg == 16'h0000;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear)
    else $error("status not cleared on configuration exit");

  property p_irq;
    ##1 int_request == |(isr_reg & ier_reg);
  endproperty
  a_irq: assert property (p_irq)
    else $error("request does not match enabled flags");

  property p_fatal;
    fatal_detect && !config_exit |=> isr_reg[BIT_FATAL] && error_level_field == LVL_RED && diag_stop;
  endproperty
  a_fatal: assert property (p_fatal)
    else $error("fatal did not force diagnosis stop");

  property p_lvl_flag;
    !config_exit && $changed(lvl_next) && lvl_next != lvl_reg |=> isr_reg[BIT_LVL_CHANGE];
  endproperty
  a_lvl_flag: assert property (p_lvl_flag)
    else $error("level change flag missed");

  property p_bus_wait;
    bus_req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus answer not in one cycle");

endmodule

// *** dv/psi_host_model.sv ***
// Host model that runs Avalon-MM register cycles against the status block
module psi_host_model
(
  input  wire logic        mclk,            // Clock
  input  wire logic        avs_waitrequest, // Stall from block
  input  wire logic [31:0] avs_readdata,    // Read data
  output logic      [11:0] avs_address,     // Byte address
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic      [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_writedata    // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
  end
  // Request held until waitrequest is sampled low; a one in a status write clears it
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge mclk);
    avs_address   <= addr;
    avs_writedata <= wdata;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
endmodule

// *** dv/psi_status_regs_tb.sv ***
// Self-checking bench for the protocol status and interrupt register block
module psi_status_regs_tb
  import psi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_ST = {IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] A_CF = {IDX_CORR_FAIL, 2'b00};
  localparam logic [11:0] A_EL = {IDX_ERR_LEVEL, 2'b00};
  localparam logic [11:0] A_IE = {IDX_INT_ENABLE, 2'b00};
  localparam logic [11:0] A_MX = {IDX_MAX_UNCORR, 2'b00};
  logic                    mclk = 1'b0;
  logic                    rst, avs_read, avs_write, avs_waitrequest, int_request, diag_stop;
  logic                    cycle_odd, offset_meas_low, rate_pairs_low, fifo_not_empty;
  logic                    mb0_locked, host_if_error_any;
  logic [3:0]              avs_byteenable, correction_fail_count;
  logic [11:0]             avs_address;
  logic [31:0]             avs_readdata, avs_writedata, rd;
  logic [NUM_BUF-1:0]      buffer_int_flag, buffer_int_enable, buffer_is_tx;
  logic [5:0]              timer0_cycle, timer1_cycle, cycle_count_value;
  logic [13:0]             timer0_offset, timer1_offset, macrotick_value;
  logic [1:0]              guardian_error, engine_level, error_level_field;
  logic [NUM_SLOT_CNT-1:0] slot_counter_inc, slot_counter_int_mask;
  logic [8:0]              pul;
  int                      mismatches = 0, cmp_count = 0;
  // Pulse lines: 001 cfg exit, 002 active, 004 start, 008 end, 010 rx, 020 ovr, 040 sync,
  // 080 limit, 100 fatal
  wire config_exit = pul[0], normal_active_enter = pul[1], cycle_start = pul[2];
  wire cycle_end = pul[3], fifo_rx_done = pul[4], fifo_overrun = pul[5];
  wire sync_overflow = pul[6], corr_limit = pul[7], fatal_detect = pul[8];

  psi_status_regs i_psi_status_regs (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .config_exit,
    .normal_active_enter, .cycle_start, .cycle_end, .cycle_odd, .offset_meas_low,
    .rate_pairs_low, .buffer_int_flag, .buffer_int_enable, .buffer_is_tx, .fifo_rx_done,
    .fifo_not_empty, .mb0_locked, .fifo_overrun, .host_if_error_any, .timer0_cycle,
    .timer0_offset, .timer1_cycle, .timer1_offset, .cycle_count_value, .macrotick_value,
    .sync_overflow, .corr_limit, .guardian_error, .slot_counter_inc, .slot_counter_int_mask,
    .engine_level, .fatal_detect, .int_request, .diag_stop, .error_level_field,
    .correction_fail_count);
  psi_host_model i_psi_host_model (.mclk, .avs_waitrequest, .avs_readdata, .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata);

  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_psi_host_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    i_psi_host_model.xfer(1'b0, a, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge mclk);
    pul <= m;
    @(posedge mclk);
    pul <= 9'h000;
    @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(A_ST, 32'h00c0); // Timer flags after reset
    check(32'(int_request), 32'h0); // No request with enables clear
    timer0_offset <= 14'h0001;
    timer1_offset <= 14'h0002;
    wr(A_ST, 32'h00c0);
    rchk(A_ST, 32'h0000); // Ones clear
    wr(12'h200, 32'hffff);
    rchk(12'h200, 32'h0); // Unmapped place
    rchk(12'h03a, 32'h0); // Misaligned place
    $display("test reset done");
  endtask
  task automatic t_w1c();
    pulse(9'h024);
    rchk(A_ST, 32'h0030); // Start and overrun set
    wr(A_ST, 32'h0000);
    rchk(A_ST, 32'h0030); // Zeros keep bits
    wr(A_ST, 32'h0010);
    rchk(A_ST, 32'h0020); // Single bit cleared
    fork
      wr(A_ST, 32'h0020);
      begin
        @(posedge mclk iff (avs_write && avs_waitrequest));
        pul <= 9'h004;
        @(posedge mclk);
        pul <= 9'h000;
      end
    join
    rchk(A_ST, 32'h0020); // Set beats clear
    wr(A_ST, 32'h0020);
    $display("test w1c done");
  endtask
  task automatic t_counter();
    wr(A_MX, 32'h2);
    cycle_odd <= 1'b1;
    offset_meas_low <= 1'b1;
    repeat (3) pulse(9'h008);
    check(32'(correction_fail_count), 32'h2); // Saturates at maximum
    wr(A_CF, 32'hf);
    rchk(A_CF, 32'h2); // Writes ignored
    offset_meas_low <= 1'b0;
    pulse(9'h008);
    check(32'(correction_fail_count), 32'h0); // Good odd cycle clears
    rate_pairs_low <= 1'b1;
    pulse(9'h008);
    check(32'(correction_fail_count), 32'h1); // Rate miss counts
    rchk(A_ST, 32'h0900); // Rate miss flagged at odd end, offset flag kept
    wr(A_ST, 32'h0900);
    cycle_odd <= 1'b0;
    offset_meas_low <= 1'b1;
    pulse(9'h008);
    check(32'(correction_fail_count), 32'h1); // Even end leaves count
    rchk(A_ST, 32'h0100); // Offset miss only at even end
    pulse(9'h002);
    check(32'(correction_fail_count), 32'h0); // Entering active clears
    {offset_meas_low, rate_pairs_low} <= 2'b00;
    wr(A_ST, 32'h0100);
    $display("test counter done");
  endtask
  task automatic t_sticky();
    fifo_not_empty <= 1'b1;
    host_if_error_any <= 1'b1;
    wr(A_ST, 32'h000c);
    rchk(A_ST, 32'h000c); // Clear refused while causes stand
    {fifo_not_empty, mb0_locked, host_if_error_any} <= 3'b010;
    wr(A_ST, 32'h0004);
    rchk(A_ST, 32'h0008); // Locked buffer 0 keeps FIFO flag
    mb0_locked <= 1'b0;
    rchk(A_ST, 32'h0000); // FIFO flag drops once unlocked
    buffer_int_flag <= NUM_BUF'(8'ha8);
    buffer_int_enable <= NUM_BUF'(8'h28);
    buffer_is_tx <= NUM_BUF'(8'ha0);
    wr(A_ST, 32'h0003);
    rchk(A_ST, 32'h0003); // Receive and transmit kept
    buffer_int_enable <= NUM_BUF'(8'h08);
    rchk(A_ST, 32'h0001); // Transmit follows enabled buffers
    buffer_int_flag <= '0;
    wr(A_ST, 32'h0001);
    pulse(9'h010);
    rchk(A_ST, 32'h0001); // FIFO reception sets receive
    wr(A_ST, 32'h0001);
    $display("test sticky done");
  endtask
  task automatic t_int();
    wr(A_IE, 32'h0020);
    pulse(9'h004);
    check(32'(int_request), 32'h1); // Enabled flag requests
    wr(A_IE, 32'h0010);
    @(posedge mclk);
    check(32'(int_request), 32'h0); // Disabled flag is silent
    wr(A_IE, 32'h0020);
    wr(A_ST, 32'h0020);
    @(posedge mclk);
    check(32'(int_request), 32'h0); // Drops with the flag
    $display("test interrupt done");
  endtask
  task automatic t_level();
    engine_level <= 2'b01;
    repeat (2) @(posedge mclk);
    check(32'(error_level_field), 32'h1); // Yellow code
    rchk(A_ST, 32'h1000); // Level change flagged
    wr(A_ST, 32'h1000);
    pulse(9'h100);
    check(32'({diag_stop, error_level_field}), 32'h6); // Stop and red
    wr(A_EL, 32'h0);
    rchk(A_EL, 32'h2); // Red kept, read only
    rchk(A_ST, 32'h9000); // Fatal and level change
    pulse(9'h001);
    check(32'(diag_stop), 32'h0); // Leaving configuration releases stop
    $display("test level done");
  endtask
  task automatic t_misc();
    wr(A_ST, 32'hffff);
    guardian_error <= 2'b10;
    slot_counter_int_mask <= 8'h02;
    slot_counter_inc <= 8'h01;
    @(posedge mclk);
    {guardian_error, slot_counter_inc} <= '0;
    pulse(9'h0c0);
    rchk(A_ST, 32'h6200); // Sync, limit, guardian; masked slot silent
    slot_counter_inc <= 8'h02;
    macrotick_value <= 14'h0001;
    @(posedge mclk);
    {slot_counter_inc, macrotick_value} <= '0;
    rchk(A_ST, 32'h6640); // Slot counter and timer 0 match
    pulse(9'h001);
    rchk(A_ST, 32'h0000); // Leaving configuration clears
    $display("test misc done");
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    {pul, cycle_odd, offset_meas_low, rate_pairs_low, fifo_not_empty, mb0_locked} = '0;
    {host_if_error_any, buffer_int_flag, buffer_int_enable, buffer_is_tx} = '0;
    {timer0_cycle, timer1_cycle, cycle_count_value, timer0_offset, timer1_offset} = '0;
    {macrotick_value, guardian_error, engine_level} = '0;
    {slot_counter_inc, slot_counter_int_mask} = '0;
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_w1c();
    t_counter();
    t_sticky();
    t_int();
    t_level();
    t_misc();
    report_and_stop();
  end
  initial
  begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule
